// file: src/sofs_top.sv
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Function
// RULE1 - PID deviation flag set while PID active and difference exceeds limit
// RULE2 - Deviation flag follows comparison each cycle, drops when excess ends
// RULE3 - Code 04 routes deviation flag to output 11 or 12
// RULE4 - Break polarity: asserted function drives output low
// RULE5 - Code 05 routes fault alarm flag, set by any drive fault
// RULE6 - Fault alarm becomes active about 300 ms after fault; fault_alarm_flag rises the next cycle, only the code 05 source waits
// RULE7 - Relay selector codes 00 to 05, reset value 05
// RULE8 - Relay polarity resets to 01; 01 closes A when healthy, 00 on fault
// RULE9 - Default polarity: relay energised normally, released on fault
// RULE10 - Inverted polarity: relay energised only on fault
// RULE11 - Most recent fault code kept in non-volatile store
// RULE12 - After power-up no fault shown on relay despite stored fault
// RULE13 - Break-contact fault output holds fault level briefly after power-up
// RULE14 - Outside equipment latches fault across power cycle itself
// RULE15 - Output codes 00..05; output 11 resets to 01, output 12 to 00
// RULE16 - Output polarity 00 make, 01 break, reset 01
// RULE17 - Delays come from parameterised counters on the control clock
module sofs_top #(
    parameter int FAULT_DELAY = sofs_pkg::FAULT_DELAY_CYC,
    parameter int INIT_DELAY = sofs_pkg::INIT_DELAY_CYC,
    parameter int DW = 22
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    // Status conditions from the drive
    input wire logic run_flag,
    input wire logic freq_reached_flag,
    input wire logic freq_exceeded_flag,
    input wire logic overload_flag,
    input wire logic pid_active,
    input wire logic [9:0] pid_setpoint,
    input wire logic [9:0] pid_actual,
    input wire logic fault_event,
    input wire logic [7:0] fault_code,
    // Non-volatile fault store
    input wire logic [7:0] nv_fault_code,
    output logic nv_wr,
    output logic [7:0] nv_wdata,
    // Outputs
    output logic out11,
    output logic out12,
    output logic relay_contact_a,
    output logic relay_contact_b,
    output logic pid_deviation_flag,
    output logic fault_alarm_flag
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] out11_function_select;
        logic [7:0] out12_function_select;
        logic [7:0] relay_function_select;
        logic [7:0] relay_polarity_select;
        logic [7:0] out_polarity_select;
        logic [9:0] pid_deviation_limit;
        logic fault_pending;
        logic pid_dev;
        logic init_busy;
        logic [7:0] last_fault;
        logic [7:0] rdata;
        logic nv_wr;
        logic [7:0] nv_wdata;
        logic out11;
        logic out12;
        logic contact_a;
        logic contact_b;
    } sofs_state_s;

    sofs_state_s state_reg;
    sofs_state_s state_next;
    logic fault_done;
    logic init_done;
    logic [9:0] diff;
    logic [5:0] cond;
    logic fault_flag;

    // Function code to condition; unknown codes give inactive
    function automatic logic pick(input logic [7:0] code, input logic [5:0] c);
        pick = (code <= sofs_pkg::FN_FAULT) ? c[code[2:0]] : 1'b0;
    endfunction

    // ****************************************
    // Delays
    // ****************************************
    sofs_delay #(.WIDTH(DW)) u_fault_dly ( // RULE17
        .ref_clk(ref_clk),
        .nrst(nrst),
        .level(state_reg.fault_pending),
        .length(DW'(FAULT_DELAY)),
        .done(fault_done)
    );

    sofs_delay #(.WIDTH(DW)) u_init_dly ( // RULE17
        .ref_clk(ref_clk),
        .nrst(nrst),
        .level(state_reg.init_busy),
        .length(DW'(INIT_DELAY)),
        .done(init_done)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        diff = (pid_setpoint > pid_actual) ? pid_setpoint - pid_actual : pid_actual - pid_setpoint;
        state_next.pid_dev = pid_active && (diff > state_reg.pid_deviation_limit); // RULE1 RULE2
        // Fault flag held low until alarm delay elapses; stays until cleared
        fault_flag = fault_done && !state_reg.init_busy; // RULE6 RULE12
        cond = {fault_flag, state_reg.pid_dev, overload_flag, freq_exceeded_flag,
                freq_reached_flag, run_flag}; // RULE15
        state_next.nv_wr = 1'b0;
        if (fault_event) begin
            state_next.fault_pending = 1'b1; // RULE5
            state_next.last_fault = fault_code;
            state_next.nv_wr = 1'b1; // RULE11
            state_next.nv_wdata = fault_code;
        end else if (wr_stb && addr == sofs_pkg::ADDR_FAULT_CLR) begin
            state_next.fault_pending = 1'b0;
        end
        if (init_done) begin
            state_next.init_busy = 1'b0;
        end
        if (wr_stb) begin
            unique case (addr)
                sofs_pkg::ADDR_OUT11_FUNC: begin
                    if (wdata <= sofs_pkg::FN_FAULT) state_next.out11_function_select = wdata; // RULE3
                end
                sofs_pkg::ADDR_OUT12_FUNC: begin
                    if (wdata <= sofs_pkg::FN_FAULT) state_next.out12_function_select = wdata; // RULE3
                end
                sofs_pkg::ADDR_RELAY_FUNC: begin
                    if (wdata <= sofs_pkg::FN_FAULT) state_next.relay_function_select = wdata; // RULE7
                end
                sofs_pkg::ADDR_RELAY_POL: begin
                    if (wdata <= sofs_pkg::POL_BREAK) state_next.relay_polarity_select = wdata; // RULE8
                end
                sofs_pkg::ADDR_OUT_POL: begin
                    if (wdata <= sofs_pkg::POL_BREAK) state_next.out_polarity_select = wdata; // RULE16
                end
                sofs_pkg::ADDR_PID_LIMIT: begin
                    // Limit in whole percent at this port, kept in tenths
                    if (wdata <= 8'h64) state_next.pid_deviation_limit = 10'(wdata) * 10'h00a; // RULE1
                end
                default: begin
                end
            endcase
        end
        state_next.rdata = 8'h00;
        if (rd_stb) begin
            unique case (addr)
                sofs_pkg::ADDR_OUT11_FUNC: state_next.rdata = state_reg.out11_function_select;
                sofs_pkg::ADDR_OUT12_FUNC: state_next.rdata = state_reg.out12_function_select;
                sofs_pkg::ADDR_RELAY_FUNC: state_next.rdata = state_reg.relay_function_select;
                sofs_pkg::ADDR_RELAY_POL: state_next.rdata = state_reg.relay_polarity_select;
                sofs_pkg::ADDR_OUT_POL: state_next.rdata = state_reg.out_polarity_select;
                sofs_pkg::ADDR_PID_LIMIT: state_next.rdata = 8'(state_reg.pid_deviation_limit / 10'h00a);
                sofs_pkg::ADDR_STATUS: state_next.rdata = {1'b0, state_reg.init_busy, cond};
                sofs_pkg::ADDR_LAST_FAULT: state_next.rdata = state_reg.last_fault;
                default: state_next.rdata = 8'h00;
            endcase
        end
        // Break polarity inverts; during init a break output set to code 05 shows its fault level
        state_next.out11 = (state_reg.out_polarity_select == sofs_pkg::POL_BREAK) ?
            !pick(state_reg.out11_function_select, cond) : pick(state_reg.out11_function_select, cond); // RULE4
        state_next.out12 = (state_reg.out_polarity_select == sofs_pkg::POL_BREAK) ?
            !pick(state_reg.out12_function_select, cond) : pick(state_reg.out12_function_select, cond); // RULE4
        if (state_reg.init_busy && state_reg.out_polarity_select == sofs_pkg::POL_BREAK) begin
            if (state_reg.out11_function_select == sofs_pkg::FN_FAULT) state_next.out11 = 1'b0; // RULE13
            if (state_reg.out12_function_select == sofs_pkg::FN_FAULT) state_next.out12 = 1'b0; // RULE13
        end
        // Contact A closed when relay energised
        state_next.contact_a = (state_reg.relay_polarity_select == sofs_pkg::POL_BREAK) ?
            !pick(state_reg.relay_function_select, cond) : pick(state_reg.relay_function_select, cond); // RULE9 RULE10
        if (state_reg.init_busy) begin
            state_next.contact_a = 1'b0;
        end
        state_next.contact_b = !state_next.contact_a; // RULE9 RULE10
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_reg <= '0;
            state_reg.out11_function_select <= sofs_pkg::RST_OUT11_FUNC; // RULE15
            state_reg.out12_function_select <= sofs_pkg::RST_OUT12_FUNC; // RULE15
            state_reg.relay_function_select <= sofs_pkg::RST_RELAY_FUNC; // RULE7
            state_reg.relay_polarity_select <= sofs_pkg::RST_RELAY_POL; // RULE8
            state_reg.out_polarity_select <= sofs_pkg::RST_OUT_POL; // RULE16
            state_reg.pid_deviation_limit <= sofs_pkg::RST_PID_LIMIT;
            state_reg.init_busy <= 1'b1;
            state_reg.out11 <= 1'b1;
            state_reg.out12 <= 1'b1;
            state_reg.contact_b <= 1'b1; // RULE12
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;
    assign nv_wr = state_reg.nv_wr;
    assign nv_wdata = state_reg.nv_wdata;
    assign out11 = state_reg.out11;
    assign out12 = state_reg.out12;
    assign relay_contact_a = state_reg.contact_a;
    assign relay_contact_b = state_reg.contact_b;
    assign pid_deviation_flag = state_reg.pid_dev;
    assign fault_alarm_flag = state_reg.fault_pending;

    // ****************************************
    // Checks
    // ****************************************
    a_pid_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE1
        pid_active && (((pid_setpoint > pid_actual) ? pid_setpoint - pid_actual : pid_actual - pid_setpoint)
        > state_reg.pid_deviation_limit) |=> pid_deviation_flag)
        else $error("pid flag missing");
    a_pid_flag_drop: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE2
        !pid_active |=> !pid_deviation_flag)
        else $error("pid flag stuck");
    a_contact_excl: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE9
        relay_contact_a != relay_contact_b)
        else $error("contacts both same");
    a_fault_no_early: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE6
        $rose(state_reg.fault_pending) |-> !fault_done [*2])
        else $error("alarm too early");
    a_fault_store: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE11
        fault_event |=> nv_wr && nv_wdata == $past(fault_code))
        else $error("fault not stored");
    a_relay_init: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE12
        $past(state_reg.init_busy) |-> !relay_contact_a)
        else $error("relay energised in init");
    a_out_break: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE4
        $past(state_reg.out_polarity_select) == sofs_pkg::POL_BREAK
        && $past(state_reg.out11_function_select) == sofs_pkg::FN_RUN && $past(run_flag) |-> !out11)
        else $error("break polarity wrong");
    a_relay_fault: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE10
        !state_reg.init_busy && state_reg.relay_polarity_select == sofs_pkg::POL_MAKE
        && state_reg.relay_function_select == sofs_pkg::FN_FAULT && !fault_done |=> !relay_contact_a)
        else $error("inverted relay closed");

    // ****************************************
    // Register port checks
    // ****************************************
    a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE15
        !rd_stb |=> rdata == 8'h00)
        else $error("read data not cleared");

    a_sel11_read: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE15
        rd_stb && addr == sofs_pkg::ADDR_OUT11_FUNC |=> rdata == $past(state_reg.out11_function_select))
        else $error("out11 selector readback");

    a_sel12_read: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE15
        rd_stb && addr == sofs_pkg::ADDR_OUT12_FUNC |=> rdata == $past(state_reg.out12_function_select))
        else $error("out12 selector readback");

    a_relay_sel_read: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE7
        rd_stb && addr == sofs_pkg::ADDR_RELAY_FUNC |=> rdata == $past(state_reg.relay_function_select))
        else $error("relay selector readback");

    a_relay_pol_read: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE8
        rd_stb && addr == sofs_pkg::ADDR_RELAY_POL |=> rdata == $past(state_reg.relay_polarity_select))
        else $error("relay polarity readback");

    a_out_pol_read: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE16
        rd_stb && addr == sofs_pkg::ADDR_OUT_POL |=> rdata == $past(state_reg.out_polarity_select))
        else $error("output polarity readback");

    a_last_fault_read: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE11
        rd_stb && addr == sofs_pkg::ADDR_LAST_FAULT |=> rdata == $past(state_reg.last_fault))
        else $error("last fault readback");

    a_stat_read: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE1
        rd_stb && addr == sofs_pkg::ADDR_STATUS |=> rdata[7] == 1'b0)
        else $error("status top bit set");

    a_sel11_range: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE15
        state_reg.out11_function_select <= sofs_pkg::FN_FAULT)
        else $error("out11 selector out of range");

    a_sel12_range: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE15
        state_reg.out12_function_select <= sofs_pkg::FN_FAULT)
        else $error("out12 selector out of range");

    a_relay_range: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE7
        state_reg.relay_function_select <= sofs_pkg::FN_FAULT)
        else $error("relay selector out of range");

    a_relay_pol_range: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE8
        state_reg.relay_polarity_select <= sofs_pkg::POL_BREAK)
        else $error("relay polarity out of range");

    a_out_pol_range: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE16
        state_reg.out_polarity_select <= sofs_pkg::POL_BREAK)
        else $error("output polarity out of range");

    a_limit_range: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE1
        state_reg.pid_deviation_limit <= sofs_pkg::PID_LIMIT_MAX)
        else $error("deviation limit out of range");

    a_sel11_write: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE3
        wr_stb && addr == sofs_pkg::ADDR_OUT11_FUNC && wdata <= sofs_pkg::FN_FAULT |=> state_reg.out11_function_select == $past(wdata))
        else $error("out11 selector not written");

    a_sel12_write: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE3
        wr_stb && addr == sofs_pkg::ADDR_OUT12_FUNC && wdata <= sofs_pkg::FN_FAULT |=> state_reg.out12_function_select == $past(wdata))
        else $error("out12 selector not written");

    a_relay_write: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE7
        wr_stb && addr == sofs_pkg::ADDR_RELAY_FUNC && wdata <= sofs_pkg::FN_FAULT |=> state_reg.relay_function_select == $past(wdata))
        else $error("relay selector not written");

    a_bad_code_kept: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE7
        wr_stb && addr == sofs_pkg::ADDR_RELAY_FUNC && wdata > sofs_pkg::FN_FAULT |=> $stable(state_reg.relay_function_select))
        else $error("illegal relay code taken");

    // ****************************************
    // Flag and output checks
    // ****************************************
    a_pid_drop: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE2
        pid_active && diff <= state_reg.pid_deviation_limit |=> !pid_deviation_flag)
        else $error("pid flag without excess");

    a_fault_latch: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE5
        fault_event |=> fault_alarm_flag)
        else $error("fault not latched");

    a_fault_clear: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE5
        wr_stb && addr == sofs_pkg::ADDR_FAULT_CLR && !fault_event |=> !fault_alarm_flag)
        else $error("fault not cleared");

    a_nv_quiet: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE11
        !fault_event |=> !nv_wr)
        else $error("stray store write");

    a_init_out: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE13
        state_reg.init_busy && state_reg.out_polarity_select == sofs_pkg::POL_BREAK
        && state_reg.out12_function_select == sofs_pkg::FN_FAULT |=> !out12)
        else $error("init fault level missing");
endmodule // sofs_top

// file: src/sofs_pkg.sv
package sofs_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [3:0] ADDR_OUT11_FUNC = 4'h0;
    localparam logic [3:0] ADDR_OUT12_FUNC = 4'h1;
    localparam logic [3:0] ADDR_RELAY_FUNC = 4'h2;
    localparam logic [3:0] ADDR_RELAY_POL = 4'h3;
    localparam logic [3:0] ADDR_OUT_POL = 4'h4;
    localparam logic [3:0] ADDR_PID_LIMIT = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_LAST_FAULT = 4'h7;
    localparam logic [3:0] ADDR_FAULT_CLR = 4'h8;

    // ****************************************
    // Function codes
    // ****************************************
    localparam logic [7:0] FN_RUN = 8'h00;
    localparam logic [7:0] FN_FREQ_REACHED = 8'h01;
    localparam logic [7:0] FN_FREQ_EXCEEDED = 8'h02;
    localparam logic [7:0] FN_OVERLOAD = 8'h03;
    localparam logic [7:0] FN_PID_DEV = 8'h04;
    localparam logic [7:0] FN_FAULT = 8'h05;
    localparam logic [7:0] POL_MAKE = 8'h00;
    localparam logic [7:0] POL_BREAK = 8'h01;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_OUT11_FUNC = 8'h01;
    localparam logic [7:0] RST_OUT12_FUNC = 8'h00;
    localparam logic [7:0] RST_RELAY_FUNC = 8'h05;
    localparam logic [7:0] RST_RELAY_POL = 8'h01;
    localparam logic [7:0] RST_OUT_POL = 8'h01;
    // Limit in tenths of a percent: 3.0 %
    localparam logic [9:0] RST_PID_LIMIT = 10'h01e;
    localparam logic [9:0] PID_LIMIT_MAX = 10'h3e8;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int FAULT_DELAY_MS = 300;
    localparam int FAULT_DELAY_CYC = FAULT_DELAY_MS * (CLK_HZ / 1000);
    localparam int INIT_DELAY_MS = 50;
    localparam int INIT_DELAY_CYC = INIT_DELAY_MS * (CLK_HZ / 1000);
endpackage

// file: src/sofs_delay.sv
`timescale 1ns/1ps
// Counts consecutive cycles of a high level; done once length reached
module sofs_delay #(
    parameter int WIDTH = 22
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Control
    input wire logic level,
    input wire logic [WIDTH-1:0] length,
    output logic done
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic done;
    } sofs_dly_s;

    sofs_dly_s state_reg;
    sofs_dly_s state_next;

    always_comb begin
        state_next = state_reg;
        if (!level) begin
            state_next.cnt = '0;
            state_next.done = 1'b0;
        end else if (state_reg.cnt >= length - WIDTH'(1)) begin
            state_next.done = 1'b1;
        end else begin
            state_next.cnt = state_reg.cnt + WIDTH'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign done = state_reg.done;
endmodule // sofs_delay

// file: verif/sofs_partner.sv
`timescale 1ns/1ps
// Outside equipment: self-holding fault relay and non-volatile fault store
module sofs_partner (
    // Clock
    input wire logic ref_clk,
    // Relay side
    input wire logic arm,
    input wire logic relay_contact_b,
    output logic held,
    // Fault store
    input wire logic nv_wr,
    input wire logic [7:0] nv_wdata,
    output logic [7:0] nv_fault_code
);
    // No reset: both must outlive a drive power cycle
    initial begin
        held = 1'b0;
        nv_fault_code = 8'h00;
    end
    always @(posedge ref_clk) begin
        if (arm && relay_contact_b) begin
            held <= 1'b1;
        end
        if (nv_wr) begin
            nv_fault_code <= nv_wdata;
        end
    end
endmodule // sofs_partner

// file: verif/sofs_tb_top.sv
`timescale 1ns/1ps
module sofs_tb_top;
    localparam int FD = 20;
    localparam int ID = 10;
    logic ref_clk, nrst, wr_stb, rd_stb, pid_active, fault_event, nv_wr, arm, held, rd_d, pin_req;
    logic [3:0] addr;
    logic [3:0] flags;
    logic [7:0] wdata, rdata, fault_code, nv_fault_code, nv_wdata;
    logic [9:0] pid_setpoint, pid_actual;
    logic out11, out12, relay_contact_a, relay_contact_b, pid_deviation_flag, fault_alarm_flag;
    logic [15:0] pin_q[$];
    logic [7:0] rd_q[$];
    int num_errors = 0;
    int compares = 0;
    wire logic [7:0] pv = {held, nv_wr, out11, out12, relay_contact_a, relay_contact_b, pid_deviation_flag,
        fault_alarm_flag};
    sofs_top #(.FAULT_DELAY(FD), .INIT_DELAY(ID)) i_sofs_top (.ref_clk(ref_clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .run_flag(flags[0]),
        .freq_reached_flag(flags[1]), .freq_exceeded_flag(flags[2]), .overload_flag(flags[3]),
        .pid_active(pid_active), .pid_setpoint(pid_setpoint), .pid_actual(pid_actual),
        .fault_event(fault_event), .fault_code(fault_code), .nv_fault_code(nv_fault_code), .nv_wr(nv_wr),
        .nv_wdata(nv_wdata), .out11(out11), .out12(out12), .relay_contact_a(relay_contact_a),
        .relay_contact_b(relay_contact_b), .pid_deviation_flag(pid_deviation_flag),
        .fault_alarm_flag(fault_alarm_flag));
    sofs_partner i_sofs_partner (.ref_clk(ref_clk), .arm(arm), .relay_contact_b(relay_contact_b), .held(held),
        .nv_wr(nv_wr), .nv_wdata(nv_wdata), .nv_fault_code(nv_fault_code));
    // ****************************************
    // Clock, pulse release, result watcher
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Fault pulse lasts exactly one cycle
    always @(posedge ref_clk) begin
        if (fault_event) begin
            fault_event <= 1'b0;
        end
        rd_d <= rd_stb;
    end
    always @(negedge ref_clk) begin
        logic [15:0] n;
        if (rd_d) begin
            check(rdata, rd_q.pop_front());
        end
        if (pin_req) begin
            n = pin_q.pop_front();
            check(pv & n[15:8], n[7:0]);
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] want);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        rd_q.push_back(want);
        @(posedge ref_clk);
        rd_stb <= 1'b0;
    endtask
    // Compares only the pins picked by the mask
    task automatic pins(input logic [7:0] mask, input logic [7:0] want);
        @(posedge ref_clk);
        pin_q.push_back({mask, want});
        pin_req <= 1'b1;
        @(posedge ref_clk);
        pin_req <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("errors %0d, compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        tally_and_finish();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int sp;
        int cnt;
        logic [7:0] code;
        {nrst, wr_stb, rd_stb, pid_active, fault_event, arm, rd_d, pin_req} = 8'h00;
        {addr, flags, wdata, fault_code, pid_setpoint, pid_actual} = 44'h0;
        void'($urandom(32'hfe91));
        idle(2);
        nrst <= 1'b1;
        pins(8'h3f, 8'h34);
        wr(4'h1, 8'h05);
        pins(8'h10, 8'h00);
        wr(4'h1, 8'h00);
        rd(4'h0, 8'h01);
        rd(4'h1, 8'h00);
        rd(4'h2, 8'h05);
        rd(4'h3, 8'h01);
        rd(4'h4, 8'h01);
        rd(4'h5, 8'h03);
        rd(4'hf, 8'h00);
        idle(ID + 2);
        pins(8'h3f, 8'h38);
        $display("test reset done");
        sp = 100 + ($urandom % 800);
        wr(4'h0, 8'h04);
        wr(4'h2, 8'h04);
        pid_setpoint <= 10'(sp);
        pid_actual <= 10'(sp + 31);
        pid_active <= 1'b1;
        idle(3);
        pins(8'h3f, 8'h16);
        rd(4'h6, 8'h10);
        pid_actual <= 10'(sp + 30);
        idle(3);
        pins(8'h3f, 8'h38);
        pid_actual <= 10'(sp + 31);
        pid_active <= 1'b0;
        idle(3);
        pins(8'h3f, 8'h38);
        pid_active <= 1'b1;
        wr(4'h4, 8'h00);
        idle(3);
        pins(8'h33, 8'h22);
        wr(4'h5, 8'h65);
        rd(4'h5, 8'h03);
        wr(4'h4, 8'h01);
        pid_active <= 1'b0;
        $display("test deviation done");
        for (int k = 0; k < 4; k++) begin
            wr(4'h2, 8'(k));
            flags <= 4'h1 << k;
            idle(3);
            pins(8'h0c, 8'h04);
            flags <= 4'h0;
            idle(3);
            pins(8'h0c, 8'h08);
        end
        wr(4'h0, 8'h00);
        flags <= 4'h1;
        idle(3);
        pins(8'h20, 8'h00);
        flags <= 4'h0;
        $display("test relay source done");
        wr(4'h2, 8'h05);
        wr(4'h1, 8'h05);
        arm <= 1'b1;
        code = 8'($urandom);
        @(posedge ref_clk);
        fault_event <= 1'b1;
        fault_code <= code;
        pins(8'hff, 8'h79);
        cnt = 0;
        while (relay_contact_a === 1'b1 && cnt < 60) begin
            @(negedge ref_clk);
            cnt++;
        end
        if (cnt >= 60) begin
            num_errors++;
            tally_and_finish();
        end
        check({7'h00, cnt >= FD - 4 && cnt <= FD + 4}, 8'h01);
        pins(8'hff, 8'ha5);
        rd(4'h7, code);
        rd(4'h6, 8'h20);
        wr(4'h3, 8'h00);
        idle(3);
        pins(8'h0c, 8'h08);
        wr(4'h8, 8'h00);
        idle(3);
        pins(8'h0d, 8'h04);
        $display("test fault done");
        wr(4'h3, 8'h01);
        @(posedge ref_clk);
        fault_event <= 1'b1;
        idle(FD + 6);
        pins(8'h0d, 8'h05);
        nrst <= 1'b0;
        idle(2);
        nrst <= 1'b1;
        pins(8'h8d, 8'h84);
        idle(ID + 2);
        pins(8'h0d, 8'h08);
        idle(2);
        $display("test power cycle done");
        tally_and_finish();
    end
endmodule // sofs_tb_top
